/* verilog/lpwv_map.svh */
`ifndef LPWV_MAP_SVH
`define LPWV_MAP_SVH

// vector pair base addresses, high byte at base, low byte at base + 1
`define LPWV_VEC_RESET  16'hFFFE
`define LPWV_VEC_BRK    16'hFFFC
`define LPWV_VEC_IRQ    16'hFFFA
`define LPWV_VEC_CG     16'hFFF8
`define LPWV_VEC_T1_CH0 16'hFFF6
`define LPWV_VEC_T1_CH1 16'hFFF4
`define LPWV_VEC_T1_OVF 16'hFFF2
`define LPWV_VEC_T2_CH0 16'hFFF0
`define LPWV_VEC_T2_CH1 16'hFFEE
`define LPWV_VEC_T2_OVF 16'hFFEC
`define LPWV_VEC_SPI_RX 16'hFFEA
`define LPWV_VEC_SPI_TX 16'hFFE8
`define LPWV_VEC_SCI_ER 16'hFFE6
`define LPWV_VEC_SCI_RX 16'hFFE4
`define LPWV_VEC_SCI_TX 16'hFFE2
`define LPWV_VEC_KBI    16'hFFE0
`define LPWV_VEC_ADC    16'hFFDE
`define LPWV_VEC_PWT    16'hFFDC

// stop recovery lengths in oscillator reference clock cycles
`define LPWV_REC_LONG  4096
`define LPWV_REC_SHORT 32
`define LPWV_REC_WIDTH 12

// number of peripheral request lines
`define LPWV_NUM_INT 16

`endif

/* verilog/lpwv_pkg.sv */
package lpwv_pkg;

   // wake controller states
   typedef enum logic [2:0] {
      ST_RUN,
      ST_WAIT,
      ST_STOP,
      ST_RECOVER,
      ST_FETCH_HI,
      ST_FETCH_LO,
      ST_FETCH_END
   } lpwv_state_type;

   // request sources, ordered by rising priority; irq pin is last
   typedef enum logic [4:0] {
      SRC_PWT,
      SRC_ADC,
      SRC_KBI,
      SRC_SCI_TX,
      SRC_SCI_RX,
      SRC_SCI_ER,
      SRC_SPI_TX,
      SRC_SPI_RX,
      SRC_T2_OVF,
      SRC_T2_CH1,
      SRC_T2_CH0,
      SRC_T1_OVF,
      SRC_T1_CH1,
      SRC_T1_CH0,
      SRC_CG,
      SRC_BRK,
      SRC_IRQ
   } lpwv_src_type;

endpackage : lpwv_pkg

/* verilog/lpwv_rec_if.sv */
`timescale 1ns/10ps
`default_nettype none

// stop recovery counter control
interface lpwv_rec_if;
   logic start;
   logic short_sel;
   logic tick;
   logic busy;
   modport ctl (output start, output short_sel, output tick, input busy);
   modport cnt (input start, input short_sel, input tick, output busy);
endinterface : lpwv_rec_if

`default_nettype wire

/* verilog/lpwv_recovery.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lpwv_map.svh"

module lpwv_recovery import lpwv_pkg::*; #(
   parameter int REC_LONG  = `LPWV_REC_LONG,
   parameter int REC_SHORT = `LPWV_REC_SHORT
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // control
   lpwv_rec_if.cnt  rec
);

   localparam logic [`LPWV_REC_WIDTH-1:0] LOAD_LONG  = (`LPWV_REC_WIDTH)'(REC_LONG - 1);
   localparam logic [`LPWV_REC_WIDTH-1:0] LOAD_SHORT = (`LPWV_REC_WIDTH)'(REC_SHORT - 1);

   logic [`LPWV_REC_WIDTH-1:0] cnt_ff;
   logic                       busy_ff;
   logic [`LPWV_REC_WIDTH:0]   seen_ff;
   logic [`LPWV_REC_WIDTH:0]   len_ff;

   // 12-bit down counter, one step per reference tick
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
      end
      else if (rec.start)
      begin
         cnt_ff  <= rec.short_sel ? LOAD_SHORT : LOAD_LONG; // [RULE_19] [RULE_20]
         busy_ff <= 1'b1;
      end
      else if (busy_ff && rec.tick)
      begin
         if (cnt_ff == '0)
            busy_ff <= 1'b0;
         else
            cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign rec.busy = busy_ff;

   // helper: ticks seen during one recovery
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         seen_ff <= '0;
         len_ff  <= '0;
      end
      else if (rec.start)
      begin
         seen_ff <= '0;
         len_ff  <= rec.short_sel ? (`LPWV_REC_WIDTH+1)'(REC_SHORT)
                                  : (`LPWV_REC_WIDTH+1)'(REC_LONG);
      end
      else if (busy_ff && rec.tick)
         seen_ff <= seen_ff + 1'b1;
   end

   a_rec_length : assert property (@(posedge clock) disable iff (sys_rst) // [RULE_19] [RULE_20]
      $fell(busy_ff) |-> seen_ff == len_ff)
      else $error("recovery length wrong");

endmodule : lpwv_recovery

`default_nettype wire

/* verilog/lpwv_top.sv */
// How it works
// RULE_01 - in stop the serial peripheral port idles; exit by reset aborts and resets it
// RULE_02 - both timers run in wait; any timer request ends wait
// RULE_03 - both timers halt in stop and resume after interrupt exit
// RULE_04 - wake timer runs in wait; its register is locked from the core
// RULE_05 - wake timer runs in stop only with oscillator kept running; register locked
// RULE_06 - any wait wake restarts the core clock and loads a vector
// RULE_07 - reset pin, watchdog or supply trip resets and fetches FFFE/FFFF
// RULE_08 - falling edge on interrupt pin wakes and fetches FFFA/FFFB
// RULE_09 - debug break wakes and fetches FFFC/FFFD
// RULE_10 - clock generator request in wait fetches FFF8/FFF9
// RULE_11 - keypad request fetches FFE0/FFE1
// RULE_12 - timer one uses FFF2 overflow, FFF4 channel one, FFF6 channel zero
// RULE_13 - timer two uses FFEC overflow, FFEE channel one, FFF0 channel zero
// RULE_14 - serial peripheral port uses FFE8 transmit and FFEA receive
// RULE_15 - async serial port uses FFE2 transmit, FFE4 receive, FFE6 errors
// RULE_16 - conversion complete uses FFDE; wake timer uses FFDC
// RULE_17 - only resets, interrupt pin, keypad, break and wake timer end stop
// RULE_18 - enabled wake timer rollover gives periodic wake from stop
// RULE_19 - after stop exit a 12-bit counter holds clocks off 4096 reference cycles
// RULE_20 - short recovery select cuts the hold to 32 reference cycles
// RULE_21 - software keeps short recovery off when a crystal drives the clock
// RULE_22 - in stop the bus clock stops unless oscillator runs in stop
// RULE_23 - stop instruction acts only when stop is enabled
// RULE_24 - vector high byte at lower address, low byte at next address
// RULE_25 - resets win over interrupts; one vector per wake
`timescale 1ns/10ps
`default_nettype none
`include "lpwv_map.svh"

module lpwv_top import lpwv_pkg::*; #(
   parameter int REC_LONG  = `LPWV_REC_LONG,
   parameter int REC_SHORT = `LPWV_REC_SHORT
) (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     sys_rst,
   // external pins
   input  wire logic                     rst_pin_n,
   input  wire logic                     irq_pin_n,
   input  wire logic                     osc_ref_clk,
   // configuration bits
   input  wire logic                     stop_enable,
   input  wire logic                     osc_run_in_stop,
   input  wire logic                     short_recovery_select,
   // core
   input  wire logic                     wait_instr,
   input  wire logic                     stop_instr,
   output logic                          core_clk_en,
   output logic                          bus_clk_en,
   // vector fetch
   output logic                          mem_rd,
   output logic [15:0]                   mem_addr,
   input  wire logic [7:0]               mem_data,
   output logic                          pc_load,
   output logic [15:0]                   pc_value,
   output logic                          wake_by_reset,
   // on-chip reset sources
   input  wire logic                     watchdog_timeout,
   input  wire logic                     svi_trip,
   // peripheral requests
   input  wire logic [`LPWV_NUM_INT-1:0] int_req,
   // peripheral control
   output logic                          dev_reset,
   output logic                          timer_run,
   output logic                          spi_hold,
   output logic                          spi_abort,
   output logic                          pwt_run,
   output logic                          pwt_access_en
);

   localparam int NSRC = `LPWV_NUM_INT + 1;

   lpwv_state_type   state_ff;
   logic [15:0]      vec_ff;
   logic             osc_lat_ff;
   logic             by_reset_ff;
   logic [7:0]       hi_ff;
   logic [15:0]      addr_ff;
   logic             rd_ff;
   logic             pc_load_ff;
   logic [15:0]      pc_ff;
   logic             dev_reset_ff;
   logic             spi_abort_ff;
   logic             rst_s1_ff;
   logic             rst_s2_ff;
   logic             irq_s1_ff;
   logic             irq_s2_ff;
   logic             irq_prev_ff;
   logic             osc_s1_ff;
   logic             osc_s2_ff;
   logic             osc_prev_ff;
   logic             reset_src;
   logic             irq_fall;
   logic [NSRC-1:0]  req_all;
   logic [NSRC-1:0]  stop_elig;
   logic             wait_wake;
   logic             stop_wake;
   lpwv_src_type     wait_pick;
   lpwv_src_type     stop_pick;
   logic             rec_go;

   lpwv_rec_if rec ();

   // vector base for each source
   function automatic logic [15:0] src_vector(input lpwv_src_type s);
      unique case (s)
         SRC_IRQ:    src_vector = `LPWV_VEC_IRQ;    // [RULE_08]
         SRC_BRK:    src_vector = `LPWV_VEC_BRK;    // [RULE_09]
         SRC_CG:     src_vector = `LPWV_VEC_CG;     // [RULE_10]
         SRC_KBI:    src_vector = `LPWV_VEC_KBI;    // [RULE_11]
         SRC_T1_OVF: src_vector = `LPWV_VEC_T1_OVF; // [RULE_12]
         SRC_T1_CH1: src_vector = `LPWV_VEC_T1_CH1; // [RULE_12]
         SRC_T1_CH0: src_vector = `LPWV_VEC_T1_CH0; // [RULE_12]
         SRC_T2_OVF: src_vector = `LPWV_VEC_T2_OVF; // [RULE_13]
         SRC_T2_CH1: src_vector = `LPWV_VEC_T2_CH1; // [RULE_13]
         SRC_T2_CH0: src_vector = `LPWV_VEC_T2_CH0; // [RULE_13]
         SRC_SPI_TX: src_vector = `LPWV_VEC_SPI_TX; // [RULE_14]
         SRC_SPI_RX: src_vector = `LPWV_VEC_SPI_RX; // [RULE_14]
         SRC_SCI_TX: src_vector = `LPWV_VEC_SCI_TX; // [RULE_15]
         SRC_SCI_RX: src_vector = `LPWV_VEC_SCI_RX; // [RULE_15]
         SRC_SCI_ER: src_vector = `LPWV_VEC_SCI_ER; // [RULE_15]
         SRC_ADC:    src_vector = `LPWV_VEC_ADC;    // [RULE_16]
         SRC_PWT:    src_vector = `LPWV_VEC_PWT;    // [RULE_16]
         default:    src_vector = `LPWV_VEC_RESET;
      endcase
   endfunction : src_vector

   // highest pending source; one winner per wake
   function automatic lpwv_src_type pick_src(input logic [NSRC-1:0] r);
      pick_src = SRC_PWT;
      for (int i = 0; i < NSRC; i++)
      begin
         if (r[i])
            pick_src = lpwv_src_type'(i); // [RULE_25]
      end
   endfunction : pick_src

   // sources allowed to end stop
   function automatic logic stop_ok(input int i, input logic osc);
      stop_ok = (i == int'(SRC_IRQ)) || (i == int'(SRC_KBI))
             || (i == int'(SRC_BRK)) // [RULE_17]
             || ((i == int'(SRC_PWT)) && osc); // [RULE_18]
   endfunction : stop_ok

   // pin synchronisers, reset pin idles high
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rst_s1_ff   <= 1'b1;
         rst_s2_ff   <= 1'b1;
         irq_s1_ff   <= 1'b1;
         irq_s2_ff   <= 1'b1;
         irq_prev_ff <= 1'b1;
      end
      else
      begin
         rst_s1_ff   <= rst_pin_n;
         rst_s2_ff   <= rst_s1_ff;
         irq_s1_ff   <= irq_pin_n;
         irq_s2_ff   <= irq_s1_ff;
         irq_prev_ff <= irq_s2_ff;
      end
   end

   // reference clock sampled as a level
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         osc_s1_ff   <= 1'b0;
         osc_s2_ff   <= 1'b0;
         osc_prev_ff <= 1'b0;
      end
      else
      begin
         osc_s1_ff   <= osc_ref_clk;
         osc_s2_ff   <= osc_s1_ff;
         osc_prev_ff <= osc_s2_ff;
      end
   end

   // reset sources and pin edge
   assign reset_src = ~rst_s2_ff | watchdog_timeout | svi_trip; // [RULE_07]
   assign irq_fall  = irq_prev_ff & ~irq_s2_ff; // [RULE_08]
   assign req_all   = {irq_fall, int_req};

   // stop filter per source
   generate
      for (genvar g = 0; g < NSRC; g++)
      begin : g_stop
         assign stop_elig[g] = req_all[g] & stop_ok(g, osc_lat_ff); // [RULE_17]
      end
   endgenerate

   // wake decisions
   assign wait_wake = |req_all; // [RULE_02] [RULE_06]
   assign stop_wake = |stop_elig;
   assign wait_pick = pick_src(req_all);
   assign stop_pick = pick_src(stop_elig);
   assign rec_go    = (state_ff == ST_STOP) && (reset_src || stop_wake);

   // recovery counter hookup
   assign rec.start     = rec_go;
   assign rec.short_sel = short_recovery_select; // [RULE_20]
   assign rec.tick      = osc_s2_ff & ~osc_prev_ff;

   lpwv_recovery #(
      .REC_LONG  (REC_LONG),
      .REC_SHORT (REC_SHORT)
   ) u_rec (
      .clock   (clock),
      .sys_rst (sys_rst),
      .rec     (rec)
   );

   // main mode sequence
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_ff    <= ST_RUN;
         vec_ff      <= `LPWV_VEC_RESET;
         osc_lat_ff  <= 1'b0;
         by_reset_ff <= 1'b0;
      end
      else
      begin
         unique case (state_ff)
            ST_RUN:
            begin
               if (reset_src)
               begin
                  vec_ff      <= `LPWV_VEC_RESET; // [RULE_07]
                  by_reset_ff <= 1'b1;
                  state_ff    <= ST_FETCH_HI;
               end
               else if (wait_instr)
                  state_ff <= ST_WAIT;
               else if (stop_instr && stop_enable) // [RULE_23]
               begin
                  osc_lat_ff <= osc_run_in_stop;
                  state_ff   <= ST_STOP;
               end
            end
            ST_WAIT:
            begin
               if (reset_src || wait_wake) // [RULE_06]
               begin
                  vec_ff      <= reset_src ? `LPWV_VEC_RESET : src_vector(wait_pick);
                  by_reset_ff <= reset_src; // [RULE_25]
                  state_ff    <= ST_FETCH_HI;
               end
            end
            ST_STOP:
            begin
               if (rec_go) // [RULE_17]
               begin
                  vec_ff      <= reset_src ? `LPWV_VEC_RESET : src_vector(stop_pick);
                  by_reset_ff <= reset_src; // [RULE_25]
                  state_ff    <= ST_RECOVER;
               end
            end
            ST_RECOVER:
            begin
               if (!rec.busy) // [RULE_19]
                  state_ff <= ST_FETCH_HI;
            end
            ST_FETCH_HI, ST_FETCH_LO, ST_FETCH_END:
            begin
               if (reset_src && !by_reset_ff)
               begin
                  vec_ff      <= `LPWV_VEC_RESET; // [RULE_25]
                  by_reset_ff <= 1'b1;
                  state_ff    <= ST_FETCH_HI;
               end
               else if (state_ff == ST_FETCH_HI)
                  state_ff <= ST_FETCH_LO;
               else if (state_ff == ST_FETCH_LO)
                  state_ff <= ST_FETCH_END;
               else
                  state_ff <= ST_RUN;
            end
         endcase
      end
   end

   // byte fetch address and strobe
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_ff   <= 1'b0;
         addr_ff <= '0;
      end
      else
      begin
         rd_ff   <= 1'b0;
         addr_ff <= addr_ff;
         unique case (state_ff)
            ST_RUN:
            begin
               if (reset_src)
               begin
                  rd_ff   <= 1'b1;
                  addr_ff <= `LPWV_VEC_RESET;
               end
            end
            ST_WAIT:
            begin
               if (reset_src || wait_wake)
               begin
                  rd_ff   <= 1'b1;
                  addr_ff <= reset_src ? `LPWV_VEC_RESET : src_vector(wait_pick);
               end
            end
            ST_STOP:
            begin
            end
            ST_RECOVER:
            begin
               if (!rec.busy)
               begin
                  rd_ff   <= 1'b1;
                  addr_ff <= vec_ff;
               end
            end
            ST_FETCH_HI, ST_FETCH_LO, ST_FETCH_END:
            begin
               if (reset_src && !by_reset_ff)
               begin
                  rd_ff   <= 1'b1;
                  addr_ff <= `LPWV_VEC_RESET;
               end
               else if (state_ff == ST_FETCH_HI)
               begin
                  rd_ff   <= 1'b1;
                  addr_ff <= vec_ff + 16'h0001; // [RULE_24]
               end
            end
         endcase
      end
   end

   // assemble program counter, high byte first
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hi_ff      <= '0;
         pc_ff      <= '0;
         pc_load_ff <= 1'b0;
      end
      else
      begin
         pc_load_ff <= 1'b0;
         if (state_ff == ST_FETCH_LO)
            hi_ff <= mem_data; // [RULE_24]
         if (state_ff == ST_FETCH_END && !(reset_src && !by_reset_ff))
         begin
            pc_ff      <= {hi_ff, mem_data}; // [RULE_24]
            pc_load_ff <= 1'b1;
         end
      end
   end

   // device reset and serial port abort
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dev_reset_ff <= 1'b1;
         spi_abort_ff <= 1'b0;
      end
      else
      begin
         dev_reset_ff <= reset_src; // [RULE_07]
         spi_abort_ff <= (state_ff == ST_STOP) && reset_src; // [RULE_01]
      end
   end

   // clock gating and peripheral run controls
   assign core_clk_en   = (state_ff == ST_RUN); // [RULE_06]
   assign bus_clk_en    = (state_ff == ST_STOP) ? osc_lat_ff // [RULE_22]
                        : (state_ff != ST_RECOVER); // [RULE_19]
   assign timer_run     = (state_ff != ST_STOP) && (state_ff != ST_RECOVER); // [RULE_02] [RULE_03]
   assign spi_hold      = (state_ff == ST_STOP) || (state_ff == ST_RECOVER); // [RULE_01]
   assign pwt_run       = (state_ff == ST_STOP) ? osc_lat_ff : 1'b1; // [RULE_04] [RULE_05]
   assign pwt_access_en = (state_ff == ST_RUN); // [RULE_04] [RULE_05]

   // registered data outputs
   assign mem_rd        = rd_ff;
   assign mem_addr      = addr_ff;
   assign pc_load       = pc_load_ff;
   assign pc_value      = pc_ff;
   assign wake_by_reset = by_reset_ff;
   assign dev_reset     = dev_reset_ff;
   assign spi_abort     = spi_abort_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_stop_gate : assert property ( // [RULE_23]
      state_ff == ST_RUN && stop_instr && !stop_enable && !reset_src
      |=> state_ff != ST_STOP)
      else $error("stop entered while disabled");

   a_bus_gate : assert property ( // [RULE_22]
      state_ff == ST_STOP |-> bus_clk_en == osc_lat_ff)
      else $error("bus clock wrong in stop");

   a_timer_halt : assert property ( // [RULE_03]
      rec_go |=> !timer_run [*2])
      else $error("timers ran during stop exit");

   a_wait_units : assert property ( // [RULE_02]
      state_ff == ST_WAIT |-> timer_run && pwt_run && !pwt_access_en)
      else $error("unit state wrong in wait");

   a_pwt_stop : assert property ( // [RULE_05]
      state_ff == ST_STOP |-> pwt_run == osc_lat_ff && !pwt_access_en)
      else $error("wake timer state wrong in stop");

   a_spi_abort : assert property ( // [RULE_01]
      state_ff == ST_STOP && reset_src |=> spi_abort && state_ff == ST_RECOVER)
      else $error("serial port abort missing");

   a_reset_vec : assert property ( // [RULE_07]
      state_ff == ST_WAIT && reset_src |=> mem_rd && mem_addr == `LPWV_VEC_RESET)
      else $error("reset vector not fetched");

   a_irq_vec : assert property ( // [RULE_08]
      state_ff == ST_WAIT && irq_fall && !reset_src
      |=> mem_rd && mem_addr == `LPWV_VEC_IRQ)
      else $error("pin vector not fetched");

   a_pair_order : assert property ( // [RULE_24]
      state_ff == ST_FETCH_END && !(reset_src && !by_reset_ff)
      |=> pc_load && pc_value == {$past(mem_data, 2), $past(mem_data)})
      else $error("vector bytes paired wrong");

   a_stop_only : assert property ( // [RULE_17]
      state_ff == ST_STOP && !reset_src && !stop_wake |=> state_ff == ST_STOP)
      else $error("stop left without a stop source");

   a_wait_wake : assert property ( // [RULE_06]
      state_ff == ST_WAIT && (reset_src || wait_wake)
      |=> state_ff == ST_FETCH_HI ##[3:6] pc_load) // one reset restart at most
      else $error("wait not left on request");

endmodule : lpwv_top

`default_nettype wire

/* dv/lpwv_vec_mem.sv */
`timescale 1ns/10ps
`default_nettype none

// vector memory seen by the fetch port
module lpwv_vec_mem (
   // clock
   input  wire logic        clock,
   // fetch port
   input  wire logic        mem_rd,
   input  wire logic [15:0] mem_addr,
   output var  logic [7:0]  mem_data
);
   initial mem_data = 8'h00;
   // byte one cycle after the strobe; toggles when idle so stale data is never valid
   always @(posedge clock)
   begin
      if (mem_rd)
         mem_data <= mem_addr[7:0] ^ 8'h5A;
      else
         mem_data <= ~mem_data;
   end
endmodule : lpwv_vec_mem

`default_nettype wire

/* dv/test_low_power_wake_vector_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lpwv_map.svh"

module test_low_power_wake_vector_control;
   import lpwv_pkg::*;
   logic        clock, sys_rst, rst_pin_n, irq_pin_n, osc_ref_clk;
   logic        stop_enable, osc_run_in_stop, short_recovery_select;
   logic        wait_instr, stop_instr, watchdog_timeout, svi_trip;
   logic        core_clk_en, bus_clk_en, mem_rd, pc_load, wake_by_reset;
   logic        dev_reset, timer_run, spi_hold, spi_abort, pwt_run, pwt_access_en;
   logic [15:0] mem_addr, pc_value;
   logic [7:0]  mem_data;
   logic [`LPWV_NUM_INT-1:0] int_req;
   int          fails, n_tests, n_rec;
   logic [15:0] vtab [16] = '{16'hFFDC, 16'hFFDE, 16'hFFE0, 16'hFFE2, 16'hFFE4, 16'hFFE6,
      16'hFFE8, 16'hFFEA, 16'hFFEC, 16'hFFEE, 16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFF6,
      16'hFFF8, 16'hFFFC};

   lpwv_top #(.REC_LONG(16), .REC_SHORT(4)) i_dut (.clock(clock), .sys_rst(sys_rst),
      .rst_pin_n(rst_pin_n), .irq_pin_n(irq_pin_n), .osc_ref_clk(osc_ref_clk),
      .stop_enable(stop_enable), .osc_run_in_stop(osc_run_in_stop),
      .short_recovery_select(short_recovery_select), .wait_instr(wait_instr),
      .stop_instr(stop_instr), .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en),
      .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data), .pc_load(pc_load),
      .pc_value(pc_value), .wake_by_reset(wake_by_reset),
      .watchdog_timeout(watchdog_timeout), .svi_trip(svi_trip), .int_req(int_req),
      .dev_reset(dev_reset), .timer_run(timer_run), .spi_hold(spi_hold),
      .spi_abort(spi_abort), .pwt_run(pwt_run), .pwt_access_en(pwt_access_en));
   lpwv_vec_mem i_mem (.clock(clock), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_data(mem_data));

   // clocks and recovery tick counter
   initial begin clock = 0; forever #20 clock = ~clock; end
   // reference edges kept off the system clock edges
   initial begin osc_ref_clk = 0; #10; forever #100 osc_ref_clk = ~osc_ref_clk; end
   always @(posedge osc_ref_clk) if (bus_clk_en === 1'b0) n_rec++;

   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   // waits for the vector load and compares the assembled program counter
   task wait_pc(input logic [15:0] v);
      int k;
      for (k = 0; k < 400 && pc_load !== 1'b1; k++) begin @(posedge clock); #1; end
      check({15'h0, pc_load}, 16'h1);
      check(pc_value, {v[7:0] ^ 8'h5A, (v[7:0] + 8'h01) ^ 8'h5A});
      check({15'h0, core_clk_en}, 16'h1);
      @(negedge clock);
      int_req = '0;
   endtask : wait_pc

   task enter(input logic stop);
      @(negedge clock);
      wait_instr = !stop;
      stop_instr = stop;
      @(negedge clock);
      wait_instr = 0;
      stop_instr = 0;
   endtask : enter

   task t_wait_all;
      for (int i = 0; i < 16; i++)
      begin
         enter(0);
         check({core_clk_en, timer_run, pwt_run, pwt_access_en}, 16'h6);
         int_req[i] = 1;
         wait_pc(vtab[i]);
      end
      // pin edge ends wait as well
      enter(0);
      irq_pin_n = 0;
      wait_pc(16'hFFFA);
      irq_pin_n = 1;
   endtask : t_wait_all

   task t_stop_irq(input logic s);
      short_recovery_select = s;
      osc_run_in_stop = 0;
      enter(1);
      check({bus_clk_en, timer_run, spi_hold, pwt_run}, 16'h2);
      int_req[13] = 1;
      repeat (10) @(negedge clock);
      check({15'h0, core_clk_en}, 16'h0);
      irq_pin_n = 0;
      n_rec = 0;
      wait_pc(16'hFFFA);
      irq_pin_n = 1;
      check({15'h0, n_rec >= (s ? 3 : 15) && n_rec <= (s ? 6 : 18)}, 16'h1);
   endtask : t_stop_irq

   task t_stop_src;
      automatic int src [3] = '{0, 2, 15};
      short_recovery_select = 1;
      for (int i = 0; i < 3; i++)
      begin
         osc_run_in_stop = (i == 0);
         enter(1);
         check({bus_clk_en, pwt_run}, (i == 0) ? 16'h3 : 16'h0);
         int_req[src[i]] = 1;
         wait_pc(vtab[src[i]]);
      end
   endtask : t_stop_src

   task t_stop_off;
      stop_enable = 0;
      enter(1);
      repeat (3) @(negedge clock);
      check({15'h0, core_clk_en}, 16'h1);
      stop_enable = 1;
   endtask : t_stop_off

   task t_resets;
      int k;
      enter(1);
      rst_pin_n = 0;
      for (k = 0; k < 10 && spi_abort !== 1'b1; k++) begin @(posedge clock); #1; end
      check({15'h0, spi_abort}, 16'h1);
      wait_pc(16'hFFFE);
      check({14'h0, wake_by_reset, dev_reset}, 16'h3);
      rst_pin_n = 1;
      repeat (4) @(negedge clock);
      enter(0);
      watchdog_timeout = 1;
      int_req[15] = 1;
      wait_pc(16'hFFFE);
      watchdog_timeout = 0;
      repeat (2) @(negedge clock);
      svi_trip = 1;
      wait_pc(16'hFFFE);
      svi_trip = 0;
   endtask : t_resets

   task end_sim;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   // main sequence
   initial
   begin
      {rst_pin_n, irq_pin_n, stop_enable} = 3'b111;
      {osc_run_in_stop, short_recovery_select, wait_instr, stop_instr} = 4'h0;
      {watchdog_timeout, svi_trip} = 2'b00;
      int_req = '0;
      sys_rst = 1;
      repeat (8) @(negedge clock);
      sys_rst = 0;
      t_wait_all();
      t_stop_irq(1);
      t_stop_irq(0); // full recovery kept, as software must with a crystal
      t_stop_src();
      t_stop_off();
      t_resets();
      end_sim();
   end

   // watchdog
   initial
   begin
      #400000;
      fails++;
      end_sim();
   end
endmodule : test_low_power_wake_vector_control

`default_nettype wire
